/* File: hdl/fsk_demod_ring_carrier_ctrl.v */
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "fsk_ctrl_regs.vh"

// What this block does
// - Demodulator-on bit enables the demodulator; readable; resets to 0.
// - While on, serial-2 receive input comes from the demodulator output.
// - While on, all four port-3 pins are general I/O.
// - When off, port-3 pins follow the serial-2 pin-select setting.
// - Ring-present reads live ring detection; writes ignored.
// - Ring-present resets to 0 in the sync flop, then follows the ring input.
// - Carrier-present reads live carrier status; read-only; 0 after reset.
// - Ring edge-select: 1 falling, 0 rising; read/write; resets 0.
// - Carrier edge-select: 1 falling, 0 rising; read/write; resets 0.
// - Flags set on selected edge even when masked.
// - Interrupt request only when flag and mask are both 1.
// - Flags clear on write of 1, ignore 0, reset to 0.
// - Mask bits read/write, ring bit 1, carrier bit 0, reset 0.
// - Unused register bits read 0 and have no storage.
// - Demodulated stream is received by serial-2 into its data register.
// - Edge condition is status changing away from the edge-select value.
module fsk_demod_ring_carrier_ctrl
(
    input  wire        i_mclk,
    input  wire        i_resetn,
    // Classic Wishbone slave
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_wb_we,
    input  wire [17:0] i_wb_adr,
    input  wire [3:0]  i_wb_sel,
    input  wire [31:0] i_wb_dat,
    output wire [31:0] o_wb_dat,
    output wire        o_wb_ack,
    // Analog front end
    input  wire        i_ring_detect_input,
    input  wire        i_carrier_detect,
    input  wire        i_demod_data,
    output wire        o_demod_enable,
    // Serial interface 2 and port 3
    input  wire        i_serial2_rx_pin,
    input  wire        i_serial2_pin_select,
    output wire        o_serial2_rx_data,
    output wire        o_port3_serial_mode,
    // Interrupt request to the CPU interrupt controller
    output wire        o_detect_irq
);

    // ========================================
    // Register state
    // ========================================
    reg        demod_on_q;
    reg  [1:0] edge_sel_q;
    reg  [1:0] irq_mask_q;
    reg  [1:0] irq_flag_q;
    reg  [1:0] irq_flag_d;
    reg  [1:0] det_prev_q;
    reg        ack_q;
    reg  [31:0] rdat_q;
    reg  [3:0] rd_nib;

    wire [1:0] det_sync;
    wire [1:0] det_edge;
    wire       req;
    wire       wr;
    wire       lane0;
    wire [15:0] idx;
    wire       hit_ctl;
    wire       hit_edge;
    wire       hit_en;
    wire       hit_flag;

    // ========================================
    // Detector synchronisation and edge detect
    // ========================================
    detect_sync u_sync
    (
        .i_mclk   (i_mclk),
        .i_resetn (i_resetn),
        .i_async  ({i_ring_detect_input, i_carrier_detect}),
        .o_sync   (det_sync)
    );

    always @(posedge i_mclk)
    begin
        if (!i_resetn)
            det_prev_q <= 2'h0;
        else
            det_prev_q <= det_sync;
    end

    // A change away from the compare value fires; rising when 0,
    // falling when 1, so copying status re-arms for the other edge.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_edge
            assign det_edge[g] = (det_prev_q[g] == edge_sel_q[g]) &&
                                 (det_sync[g] != edge_sel_q[g]);
        end
    endgenerate

    // ========================================
    // Wishbone decode
    // ========================================
    assign req      = i_wb_cyc & i_wb_stb & ~ack_q;
    assign wr       = req & i_wb_we;
    assign lane0    = i_wb_sel[0];
    assign idx      = i_wb_adr[17:2];
    assign hit_ctl  = (idx == `REG_DEMOD_CTRL_STATUS);
    assign hit_edge = (idx == `REG_DETECT_EDGE_SEL);
    assign hit_en   = (idx == `REG_DETECT_IRQ_EN);
    assign hit_flag = (idx == `REG_DETECT_IRQ_FLAGS);

    // ========================================
    // Control registers
    // ========================================
    always @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            demod_on_q <= `RST_DEMOD_ON;
            edge_sel_q <= `RST_EDGE_SEL;
            irq_mask_q <= `RST_IRQ_MASK;
        end
        else if (wr && lane0)
        begin
            if (hit_ctl)
                demod_on_q <= i_wb_dat[`BIT_DEMOD_ON];
            if (hit_edge)
                edge_sel_q <= i_wb_dat[1:0];
            if (hit_en)
                irq_mask_q <= i_wb_dat[1:0];
        end
    end

    // Set wins over a clear landing in the same cycle
    always @*
    begin
        irq_flag_d = irq_flag_q;
        if (wr && lane0 && hit_flag)
            irq_flag_d = irq_flag_q & ~i_wb_dat[1:0];
        irq_flag_d = irq_flag_d | det_edge;
    end

    always @(posedge i_mclk)
    begin
        if (!i_resetn)
            irq_flag_q <= `RST_IRQ_FLAG;
        else
            irq_flag_q <= irq_flag_d;
    end

    assign o_detect_irq = |(irq_flag_q & irq_mask_q);

    // ========================================
    // Read path, one wait state free: ack one cycle after request
    // ========================================
    // Status is live from the synchroniser, so both bits track the
    // pins after reset; ring and carrier sync flops reset to 0.
    always @*
    begin
        rd_nib = 4'h0;
        if (hit_ctl)
        begin
            rd_nib[`BIT_DEMOD_ON] = demod_on_q;
            rd_nib[`BIT_RING]     = det_sync[`BIT_RING];
            rd_nib[`BIT_CARRIER]  = det_sync[`BIT_CARRIER];
        end
        else if (hit_edge)
            rd_nib[1:0] = edge_sel_q;
        else if (hit_en)
            rd_nib[1:0] = irq_mask_q;
        else if (hit_flag)
            rd_nib[1:0] = irq_flag_q;
    end

    always @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0;
        end
        else
        begin
            ack_q  <= req;
            if (req && !i_wb_we)
                rdat_q <= {28'h0, rd_nib};
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    // ========================================
    // Routing to serial interface 2 and port 3
    // ========================================
    assign o_demod_enable      = demod_on_q;
    // Demodulator stream feeds serial-2 receiver while on, else the rx pin does
    assign o_serial2_rx_data   = demod_on_q ? i_demod_data
                                            : i_serial2_rx_pin;
    assign o_port3_serial_mode = ~demod_on_q &
                                 i_serial2_pin_select;

endmodule // fsk_demod_ring_carrier_ctrl

`default_nettype wire

/* File: hdl/fsk_ctrl_regs.vh */
`ifndef FSK_CTRL_REGS_VH
`define FSK_CTRL_REGS_VH

// Register word indices; byte address is index times four
`define REG_DEMOD_CTRL_STATUS 16'hff66
`define REG_DETECT_EDGE_SEL   16'hff67
`define REG_DETECT_IRQ_EN     16'hffea
`define REG_DETECT_IRQ_FLAGS  16'hfffa

// Field positions
`define BIT_DEMOD_ON          3
`define BIT_RING              1
`define BIT_CARRIER           0

// Reset values
`define RST_DEMOD_ON          1'b0
`define RST_EDGE_SEL          2'h0
`define RST_IRQ_MASK          2'h0
`define RST_IRQ_FLAG          2'h0
`define RST_CARRIER           1'b0

// Software oscillator settle time, not enforced by hardware
`define OSC_SETTLE_MS         5

`endif

/* File: hdl/detect_sync.v */
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for the detector levels
module detect_sync
(
    input  wire       i_mclk,
    input  wire       i_resetn,
    input  wire [1:0] i_async,
    output wire [1:0] o_sync
);

    reg [1:0] meta_q;
    reg [1:0] sync_q;

    always @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule // detect_sync

`default_nettype wire

/* File: tb/fsk_ctrl_checker.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fsk_ctrl_regs.vh"
// ====
// Port checks
module fsk_ctrl_checker
(
    input wire logic        i_mclk,
    input wire logic        i_resetn,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [17:0] i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        i_ring_detect_input,
    input wire logic        i_carrier_detect,
    input wire logic        i_demod_data,
    input wire logic        o_demod_enable,
    input wire logic        i_serial2_rx_pin,
    input wire logic        i_serial2_pin_select,
    input wire logic        o_serial2_rx_data,
    input wire logic        o_port3_serial_mode,
    input wire logic        o_detect_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    wire tk = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire wr = tk & i_wb_we & i_wb_sel[0];
    wire [15:0] ix = i_wb_adr[17:2];
    wire [1:0] ln = {i_ring_detect_input, i_carrier_detect};
    // Six quiet samples flush sync and edge stages
    sequence s_quiet;
        $stable(ln) [*6];
    endsequence
    sequence s_rd_ctrl;
        tk && !i_wb_we && ix == `REG_DEMOD_CTRL_STATUS;
    endsequence
    a_rx_route: assert property (
        o_serial2_rx_data ==
        (o_demod_enable ? i_demod_data : i_serial2_rx_pin))
        else $error("rx route wrong");
    a_gpio_when_on: assert property (
        o_demod_enable |-> !o_port3_serial_mode)
        else $error("port3 not general io");
    a_serial_when_off: assert property (
        !o_demod_enable |-> o_port3_serial_mode == i_serial2_pin_select)
        else $error("port3 mode wrong");
    a_demod_write: assert property (
        wr && ix == `REG_DEMOD_CTRL_STATUS
        |=> o_demod_enable == $past(i_wb_dat[3]))
        else $error("demod bit not written");
    a_demod_hold: assert property (
        !(wr && ix == `REG_DEMOD_CTRL_STATUS) |=> $stable(o_demod_enable))
        else $error("demod bit moved");
    a_unused_zero: assert property (
        o_wb_ack |-> o_wb_dat[31:4] == 28'h0 && !o_wb_dat[2])
        else $error("unused bits set");
    a_status_live: assert property (
        s_quiet ##0 s_rd_ctrl |=> o_wb_dat[1:0] == $past(ln))
        else $error("status bits wrong");
    a_flag_clear: assert property (
        s_quiet ##0 (wr && ix == `REG_DETECT_IRQ_FLAGS &&
        i_wb_dat[1:0] == 2'h3) |=> !o_detect_irq)
        else $error("flags not cleared");
    a_mask_off: assert property (
        wr && ix == `REG_DETECT_IRQ_EN && i_wb_dat[1:0] == 2'h0
        |=> !o_detect_irq)
        else $error("irq while masked");
    a_reset_clear: assert property (disable iff (1'b0)
        !i_resetn |=> !o_demod_enable && !o_detect_irq && !o_wb_ack)
        else $error("reset left state");
endmodule // fsk_ctrl_checker
bind fsk_demod_ring_carrier_ctrl fsk_ctrl_checker chk (.*);
`default_nettype wire

/* File: tb/line_front_end.sv */
`timescale 1ns/10ps
`default_nettype none
// ====
// Detector levels move off the clock grid
module line_front_end
(
    input  wire logic i_mclk,
    input  wire logic i_ring_on,
    input  wire logic i_carrier_on,
    output var logic  o_ring,
    output var logic  o_carrier,
    output var logic  o_bit
);
    initial {o_ring, o_carrier, o_bit} = 3'h1;
    always @(i_ring_on) o_ring <= #13 i_ring_on;
    always @(i_carrier_on) o_carrier <= #17 i_carrier_on;
    // Mark idles high; data toggles under carrier
    always @(posedge i_mclk) o_bit <= o_carrier ? ~o_bit : 1'b1;
endmodule // line_front_end
`default_nettype wire

/* File: tb/fsk_demod_ring_carrier_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fsk_ctrl_regs.vh"
module fsk_demod_ring_carrier_ctrl_tb;
    localparam [15:0] cs = `REG_DEMOD_CTRL_STATUS;
    localparam [15:0] es = `REG_DETECT_EDGE_SEL;
    localparam [15:0] en = `REG_DETECT_IRQ_EN;
    localparam [15:0] fl = `REG_DETECT_IRQ_FLAGS;
    logic i_mclk = 0, i_resetn = 0, i_wb_cyc = 0, i_wb_stb = 0;
    logic i_wb_we = 0, i_serial2_rx_pin = 0, i_serial2_pin_select = 1;
    logic ring_on = 0, car_on = 0;
    logic [3:0] i_wb_sel = 4'hf;
    logic [17:0] i_wb_adr = 18'h0;
    logic [31:0] i_wb_dat = 32'h0;
    wire [31:0] o_wb_dat;
    wire o_wb_ack, o_demod_enable, o_serial2_rx_data, o_port3_serial_mode;
    wire o_detect_irq, i_ring_detect_input, i_carrier_detect, i_demod_data;
    int fails = 0, comparisons = 0;
    always #25 i_mclk = ~i_mclk;
    fsk_demod_ring_carrier_ctrl DUT (.*);
    line_front_end fe (.i_mclk, .i_ring_on(ring_on), .i_carrier_on(car_on),
        .o_ring(i_ring_detect_input), .o_carrier(i_carrier_detect),
        .o_bit(i_demod_data));
    task chk(input [3:0] got, input [3:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Holds the request until ack is sampled, then idles one cycle
    task xfer(input [15:0] a, input w, input [3:0] d, input [3:0] e);
        i_wb_cyc <= 1;
        i_wb_stb <= 1;
        i_wb_we <= w;
        i_wb_adr <= {a, 2'h0};
        i_wb_dat <= {28'h0, d};
        do @(posedge i_mclk); while (o_wb_ack !== 1'b1);
        i_wb_cyc <= 0;
        i_wb_stb <= 0;
        if (!w) chk(o_wb_dat[3:0], e);
        @(posedge i_mclk);
    endtask
    task conclude;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #50000;
        fails++;
        conclude;
    end
    initial
    begin
        repeat (3) @(posedge i_mclk);
        i_resetn <= 1;
        xfer(cs, 0, 4'h0, 4'h0);
        xfer(es, 0, 4'h0, 4'h0);
        xfer(en, 0, 4'h0, 4'h0);
        xfer(fl, 0, 4'h0, 4'h0);
        xfer(cs, 1, 4'hf, 4'h0);
        xfer(cs, 0, 4'h0, 4'h8);
        chk({3'h0, o_port3_serial_mode}, 4'h0);
        chk({3'h0, o_serial2_rx_data}, 4'h1);
        xfer(cs, 1, 4'h0, 4'h0);
        chk({3'h0, o_port3_serial_mode}, 4'h1);
        xfer(es, 1, 4'hf, 4'h0);
        xfer(es, 0, 4'h0, 4'h3);
        xfer(es, 1, 4'h0, 4'h0);
        i_wb_sel <= 4'he;
        xfer(es, 1, 4'hf, 4'h0);
        i_wb_sel <= 4'hf;
        xfer(es, 0, 4'h0, 4'h0);
        xfer(en, 1, 4'hf, 4'h0);
        xfer(en, 0, 4'h0, 4'h3);
        ring_on <= 1;
        car_on <= 1;
        repeat (8) @(posedge i_mclk);
        xfer(cs, 0, 4'h0, 4'h3);
        xfer(fl, 0, 4'h0, 4'h3);
        chk({3'h0, o_detect_irq}, 4'h1);
        xfer(en, 1, 4'h0, 4'h0);
        chk({3'h0, o_detect_irq}, 4'h0);
        xfer(fl, 1, 4'h0, 4'h0);
        xfer(fl, 0, 4'h0, 4'h3);
        xfer(fl, 1, 4'h3, 4'h0);
        xfer(fl, 0, 4'h0, 4'h0);
        xfer(es, 1, 4'h3, 4'h0);
        ring_on <= 0;
        car_on <= 0;
        repeat (8) @(posedge i_mclk);
        xfer(fl, 0, 4'h0, 4'h3);
        xfer(en, 1, 4'h2, 4'h0);
        chk({3'h0, o_detect_irq}, 4'h1);
        conclude;
    end
endmodule // fsk_demod_ring_carrier_ctrl_tb
`default_nettype wire
